// [core/adc_conversion_control.sv]
// Control logic of a 10-bit successive approximation converter
// Function
// - Converter runs only while enable bit 0 of control 0 is one.
// - Writing go while enabled starts a conversion of selected channel.
// - At completion clear go, set flag, load the 10-bit result.
// - Clearing go early aborts; result keeps previous completed value.
// - After abort wait two conversion clock periods.
// - After that wait, acquisition restarts on selected channel.
// - Reset returns registers to reset values, converter off.
// - Go bit 1 reads one while converting; hardware clears it.
// - Right format: high holds bits 9..8, low holds bits 7..0.
// - Hold capacitor is never discharged between conversions.
// - A conversion lasts eleven conversion clock periods.
// - Flag is set at every completion, whatever the enable.
// - Flag is never cleared by hardware, only by software.
// - Completion raises the converter interrupt when interrupt enable is set, which wakes the device.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module adc_conversion_control (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // AXI4-Lite write channels
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Analog front end
  input  wire logic       rc_tick,
  input  wire logic       comp_hi,
  output logic            conv_power_q,
  output logic [5:0]      channel_q,
  output logic [1:0]      ref_sel_q,
  output logic            sample_q,
  output logic [9:0]      dac_code_q,
  // Interrupt request toward the interrupt controller
  output logic            irq_q
);
  import adc_pkg::*;

  conv_clk_if cif ();

  // Register state
  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [9:0]  result_q;
  logic        flag_q;
  logic        ie_q;
  conv_state_e state_q;
  logic [3:0]  conv_cnt_q;
  logic [1:0]  abort_cnt_q;
  logic [9:0]  sar_q;
  logic [9:0]  sar_d;
  // Bus state
  logic [7:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_strb_q;
  logic        aw_have_q;
  logic        w_have_q;
  // Decoded events
  logic        wr_fire;
  logic        wr_ctrl0;
  logic        wr_ctrl1;
  logic        wr_flags;
  logic        go_set;
  logic        abort_req;
  logic        done;
  logic        tick;
  logic [3:0]  bit_idx;
  logic [7:0]  res_hi;
  logic [7:0]  res_lo;

  conv_clock_gen u_clk (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .rc_tick (rc_tick),
    .cif     (cif.gen)
  );

  assign cif.clk_sel = ctrl1_q[CKS_LSB +: 3];
  // Divider restarts at an abort so the recovery spans two full periods
  assign cif.run     = (state_q != S_IDLE) && !abort_req;
  assign tick        = cif.tad_tick;

  // Write address and data are held until both have arrived
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 8'h00;
      w_strb_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write commits once both halves are in; low byte lane carries data
  assign wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ctrl0 = wr_fire && w_strb_q && aw_addr_q == OFS_CTRL0;
  assign wr_ctrl1 = wr_fire && w_strb_q && aw_addr_q == OFS_CTRL1;
  assign wr_flags = wr_fire && w_strb_q && aw_addr_q == OFS_FLAGS;

  // Write response; result registers are read only, so writes error
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_q == OFS_CTRL0 || aw_addr_q == OFS_CTRL1 ||
          aw_addr_q == OFS_FLAGS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Go only counts when the enable was already set by an earlier write
  assign go_set = wr_ctrl0 && w_data_q[GO_BIT] && ctrl0_q[EN_BIT] &&
                  w_data_q[EN_BIT] && state_q == S_IDLE;
  // Clearing go or the enable mid conversion aborts it
  assign abort_req = state_q == S_CONV && wr_ctrl0 &&
                     (!w_data_q[GO_BIT] || !w_data_q[EN_BIT]);
  assign done = state_q == S_CONV && tick &&
                conv_cnt_q == CONV_TADS - 4'h1 && !abort_req;

  // Control register 0; go is owned jointly with the sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl0_q <= CTRL0_RST;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_q[7:CHS_LSB] <= w_data_q[7:CHS_LSB];
        ctrl0_q[EN_BIT]    <= w_data_q[EN_BIT];
      end
      if (go_set) begin
        ctrl0_q[GO_BIT] <= 1'b1;
      end else if (done || abort_req) begin
        ctrl0_q[GO_BIT] <= 1'b0;
      end else if (wr_ctrl0 && !w_data_q[GO_BIT]) begin
        ctrl0_q[GO_BIT] <= 1'b0;
      end
    end
  end

  // Control register 1; bits 7 and 3 do not exist and stay zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl1_q <= CTRL1_RST;
    end else if (wr_ctrl1) begin
      ctrl1_q <= {1'b0, w_data_q[6:4], 1'b0, w_data_q[2:0]};
    end
  end

  // Sequencer: idle means acquiring, since the hold cap just tracks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q     <= S_IDLE;
      conv_cnt_q  <= 4'h0;
      abort_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          conv_cnt_q  <= 4'h0;
          abort_cnt_q <= 2'h0;
          if (go_set) begin
            state_q <= S_CONV;
          end
        end
        S_CONV: begin
          if (abort_req) begin
            state_q <= S_ABORT;
          end else if (done) begin
            state_q <= S_IDLE;
          end else if (tick) begin
            conv_cnt_q <= conv_cnt_q + 4'h1;
          end
        end
        S_ABORT: begin
          if (tick) begin
            abort_cnt_q <= abort_cnt_q + 2'h1;
            if (abort_cnt_q == ABORT_TADS - 2'h1) begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Bit under trial: period 0 samples, periods 1..10 resolve 9..0
  assign bit_idx = CONV_TADS - 4'h1 - conv_cnt_q;

  // Approximation step: keep or drop the trial bit, try the next one
  always_comb begin
    sar_d = sar_q;
    if (conv_cnt_q == 4'h0) begin
      sar_d = 10'h200;
    end else begin
      for (int i = 0; i < 10; i++) begin
        if (i == int'(bit_idx)) begin
          sar_d[i] = sar_q[i] & comp_hi;
        end else if (i + 1 == int'(bit_idx)) begin
          sar_d[i] = 1'b1;
        end
      end
    end
  end

  // Trial code driven to the converter's internal DAC
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sar_q <= 10'h000;
    end else if (state_q == S_CONV && tick) begin
      sar_q <= sar_d;
    end
  end

  // Result loads only on a finished conversion, never on an abort
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_q <= RESULT_RST;
    end else if (done) begin
      result_q <= sar_d;
    end
  end

  // Completion flag is sticky; a completion beats a software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      ie_q   <= 1'b0;
    end else begin
      if (wr_flags) begin
        ie_q <= w_data_q[IE_BIT];
      end
      if (done) begin
        flag_q <= 1'b1;
      end else if (wr_flags && !w_data_q[FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Analog side controls; sample switch closed only while enabled and idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_power_q <= 1'b0;
      channel_q    <= 6'h00;
      ref_sel_q    <= 2'h0;
      sample_q     <= 1'b0;
      dac_code_q   <= 10'h000;
      irq_q        <= 1'b0;
    end else begin
      conv_power_q <= ctrl0_q[EN_BIT];
      // Unimplemented codes fall back to channel code 0
      channel_q    <= (ctrl0_q[7:CHS_LSB] > CHS_MAX) ? 6'h00 :
                      ctrl0_q[7:CHS_LSB];
      ref_sel_q    <= ctrl1_q[REF_LSB +: 2];
      // No discharge path: idle keeps tracking the input instead
      sample_q     <= ctrl0_q[EN_BIT] && state_q == S_IDLE;
      dac_code_q   <= sar_q;
      irq_q        <= flag_q && ie_q;
    end
  end

  // Result views in both justifications
  assign res_hi = ctrl1_q[JUST_BIT] ? {6'h00, result_q[9:8]} :
                  result_q[9:2];
  assign res_lo = ctrl1_q[JUST_BIT] ? result_q[7:0] :
                  {result_q[1:0], 6'h00};

  // Read channel: one read at a time, answer one cycle after the address handshake
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == OFS_CTRL0) begin
          s_axi_rdata <= {24'h00_0000, ctrl0_q};
        end else if (s_axi_araddr == OFS_CTRL1) begin
          s_axi_rdata <= {24'h00_0000, ctrl1_q};
        end else if (s_axi_araddr == OFS_RES_HI) begin
          s_axi_rdata <= {24'h00_0000, res_hi};
        end else if (s_axi_araddr == OFS_RES_LO) begin
          s_axi_rdata <= {24'h00_0000, res_lo};
        end else if (s_axi_araddr == OFS_FLAGS) begin
          s_axi_rdata <= {30'h0000_0000, ie_q, flag_q};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks that run beside the sequencer
  sequence s_abort_begin;
    state_q == S_CONV && abort_req;
  endsequence

  sequence s_abort_leave;
    state_q == S_ABORT && tick && abort_cnt_q == ABORT_TADS - 2'h1;
  endsequence

  property p_go_needs_enable;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(ctrl0_q[GO_BIT]) |-> ctrl0_q[EN_BIT] && state_q == S_CONV;
  endproperty
  a_go_needs_enable: assert property (p_go_needs_enable)
    else $error("go rose without enable or start");

  property p_done_effects;
    @(posedge ref_clk) disable iff (!rst_n)
      done |=> flag_q && !ctrl0_q[GO_BIT] && result_q == $past(sar_d);
  endproperty
  a_done_effects: assert property (p_done_effects)
    else $error("completion did not clear go, set flag, load result");

  property p_abort_keeps;
    @(posedge ref_clk) disable iff (!rst_n)
      s_abort_begin |=> $stable(result_q) && !ctrl0_q[GO_BIT]
        && !flag_q == !$past(flag_q);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps)
    else $error("abort disturbed result or go");

  property p_abort_two;
    @(posedge ref_clk) disable iff (!rst_n)
      s_abort_begin |=> state_q == S_ABORT && abort_cnt_q == 2'h0;
  endproperty
  a_abort_two: assert property (p_abort_two)
    else $error("abort wait did not start from zero");

  property p_auto_acquire;
    @(posedge ref_clk) disable iff (!rst_n)
      s_abort_leave ##1 ctrl0_q[EN_BIT] |=> sample_q;
  endproperty
  a_auto_acquire: assert property (p_auto_acquire)
    else $error("acquisition not restarted after abort wait");

  property p_reset_off;
    @(posedge ref_clk)
      !rst_n |=> ctrl0_q == CTRL0_RST && state_q == S_IDLE
        && ctrl1_q == CTRL1_RST;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("reset did not clear the converter");

  property p_eleven;
    @(posedge ref_clk) disable iff (!rst_n)
      done |-> conv_cnt_q == 4'hA && state_q == S_CONV;
  endproperty
  a_eleven: assert property (p_eleven)
    else $error("conversion length is not eleven periods");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
      flag_q && !(wr_flags && !w_data_q[FLAG_BIT]) |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without software clear");

  property p_disabled_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !ctrl0_q[EN_BIT] ##1 !ctrl0_q[EN_BIT] |-> state_q != S_CONV;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("conversion running while disabled");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      done ##1 ie_q |=> irq_q;
  endproperty
  a_irq: assert property (p_irq)
    else $error("completion did not raise interrupt");
endmodule // adc_conversion_control

// [inc/adc_pkg.sv]
// Package of register map, field layout and counts for converter control
package adc_pkg;
  // Register byte addresses on the register bus
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RES_HI = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;
  // Field positions in converter_control_0
  localparam int EN_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHS_LSB = 2;
  // Field positions in converter_control_1
  localparam int REF_LSB = 0;
  localparam int JUST_BIT = 2;
  localparam int CKS_LSB = 4;
  // Field positions in the flag register
  localparam int FLAG_BIT = 0;
  localparam int IE_BIT = 1;
  // Highest implemented channel code
  localparam logic [5:0] CHS_MAX = 6'h1F;
  // Conversion clock select codes
  localparam logic [2:0] CKS_DIV8 = 3'h1;
  localparam logic [2:0] CKS_DIV16 = 3'h5;
  localparam logic [2:0] CKS_DIV32 = 3'h2;
  localparam logic [2:0] CKS_DIV64 = 3'h6;
  // Conversion clock divisors, ref_clk cycles or RC ticks per period
  localparam logic [6:0] DIV8 = 7'h08;
  localparam logic [6:0] DIV16 = 7'h10;
  localparam logic [6:0] DIV32 = 7'h20;
  localparam logic [6:0] DIV64 = 7'h40;
  localparam logic [6:0] RC_DIV = 7'h10;
  // Conversion clock periods per conversion and per abort recovery
  localparam logic [3:0] CONV_TADS = 4'hB;
  localparam logic [1:0] ABORT_TADS = 2'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_CONV  = 2'b01,
    S_ABORT = 2'b10
  } conv_state_e;
endpackage

// [inc/conv_clk_if.sv]
// Interface between the sequencer and the conversion clock generator
`timescale 1ns/10ps
interface conv_clk_if;
  logic [2:0] clk_sel;
  logic       run;
  logic       tad_tick;
  modport gen (input clk_sel, input run, output tad_tick);
  modport ctl (output clk_sel, output run, input tad_tick);
endinterface

// [core/conv_clock_gen.sv]
// Conversion clock generator: one tick per conversion clock period
`timescale 1ns/10ps
module conv_clock_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Internal RC oscillator tick, one cycle wide
  input wire logic rc_tick,
  // Sequencer side
  conv_clk_if.gen  cif
);
  import adc_pkg::*;

  logic [6:0] div_cnt_q;
  logic [6:0] div_sel;
  logic       rc_mode;
  logic       step;

  // Divisor from the select code; reserved codes give no clock at all
  always_comb begin
    rc_mode = (cif.clk_sel[1:0] == 2'b11);
    div_sel = 7'h00;
    if (rc_mode) begin
      div_sel = RC_DIV;
    end else if (cif.clk_sel == CKS_DIV8) begin
      div_sel = DIV8;
    end else if (cif.clk_sel == CKS_DIV16) begin
      div_sel = DIV16;
    end else if (cif.clk_sel == CKS_DIV32) begin
      div_sel = DIV32;
    end else if (cif.clk_sel == CKS_DIV64) begin
      div_sel = DIV64;
    end
    step = rc_mode ? rc_tick : 1'b1;
  end

  // Counter restarts while idle so the first period is a full one
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !cif.run || div_sel == 7'h00) begin
      div_cnt_q    <= 7'h00;
      cif.tad_tick <= 1'b0;
    end else if (step) begin
      if (div_cnt_q == div_sel - 7'h01) begin
        div_cnt_q    <= 7'h00;
        cif.tad_tick <= 1'b1;
      end else begin
        div_cnt_q    <= div_cnt_q + 7'h01;
        cif.tad_tick <= 1'b0;
      end
    end else begin
      cif.tad_tick <= 1'b0;
    end
  end
endmodule // conv_clock_gen

// [tb/analog_front_end.sv]
// Behavioural model of the input mux, hold capacitor, comparator and RC tick
`timescale 1ns/10ps
module analog_front_end #(
  parameter int RC_PER = 3
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Converter side
  input  wire logic [5:0] channel_q,
  input  wire logic       sample_q,
  input  wire logic [9:0] dac_code_q,
  // Toward the converter
  output logic            rc_tick,
  output logic            comp_hi
);
  logic [9:0] hold_q = 10'h155;
  int         rc_cnt_q = 0;

  // Capacitor tracks the routed input only while the switch is closed
  always_ff @(posedge ref_clk) begin
    if (sample_q) begin
      hold_q <= {channel_q[4:0], 5'h0B};
    end
  end

  // RC oscillator runs free, unrelated to reset or conversions
  always_ff @(posedge ref_clk) begin
    rc_cnt_q <= (rc_cnt_q == RC_PER - 1) ? 0 : rc_cnt_q + 1;
  end
  assign rc_tick = (rc_cnt_q == 0);

  // Keep the trial bit while the held level reaches the trial code
  assign comp_hi = (hold_q >= dac_code_q);
endmodule // analog_front_end

// [tb/tb.sv]
// Register-level testbench of the converter control block
`timescale 1ns/10ps
module tb;
  import adc_pkg::*;
  localparam int RC_PER = 3;
  localparam logic [2:0] cks_t [6] = '{CKS_DIV8, CKS_DIV16, CKS_DIV32,
                                       CKS_DIV64, 3'h3, 3'h7};
  localparam int per_t [6] = '{int'(DIV8), int'(DIV16), int'(DIV32),
                               int'(DIV64), int'(RC_DIV) * RC_PER,
                               int'(RC_DIV) * RC_PER};
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, ref_sel_q;
  logic [31:0] rdata;
  logic        rc_tick, comp_hi, conv_power_q, sample_q, irq_q;
  logic [5:0]  channel_q;
  logic [9:0]  dac_code_q, pv;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cyc = 0;

  adc_conversion_control adc_conversion_control_inst (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rc_tick(rc_tick), .comp_hi(comp_hi), .conv_power_q(conv_power_q),
    .channel_q(channel_q), .ref_sel_q(ref_sel_q), .sample_q(sample_q),
    .dac_code_q(dac_code_q), .irq_q(irq_q));

  analog_front_end #(.RC_PER(RC_PER)) analog_front_end_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .channel_q(channel_q),
    .sample_q(sample_q), .dac_code_q(dac_code_q), .rc_tick(rc_tick),
    .comp_hi(comp_hi));

  // Clock and a free cycle count for timing conversions
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  function automatic logic [9:0] lvl(input logic [5:0] ch);
    return {ch[4:0], 5'h0B};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A handshake that never comes ends the run instead of hanging
  task automatic guard(input int n);
    if (n > 200) begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    int   n;
    logic ad, wd;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 0;
    wd = 0;
    n = 0;
    forever begin
      @(posedge ref_clk);
      n++;
      guard(n);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        chk(bresp, er);
        break;
      end
    end
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic ad;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ad = 0;
    n = 0;
    forever begin
      @(posedge ref_clk);
      n++;
      guard(n);
      if (!ad && arready === 1'b1) begin
        ad = 1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(negedge ref_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask

  // One full conversion, checked in both result formats
  task automatic conv(input logic [2:0] cks, input logic [5:0] ch,
                      input int per);
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  v;
    int          t0;
    int          n;
    v = lvl(ch);
    wr(OFS_CTRL1, {25'h0, cks, 4'h4});
    wr(OFS_CTRL0, {24'h0, ch, 2'b01});
    repeat (10) @(negedge ref_clk);
    wr(OFS_CTRL0, {24'h0, ch, 2'b11});
    t0 = cyc;
    n = 0;
    do begin
      // Spaced polls keep the slowest clock inside the poll bound
      if (n > 0) repeat (4) @(negedge ref_clk);
      rd(OFS_CTRL0, d, r);
      if (n == 0) chk(d, {24'h0, ch, 2'b11});
      n++;
      guard(n);
    end while (d[GO_BIT] === 1'b1);
    chk(d, {24'h0, ch, 2'b01});
    chk(cyc - t0 >= per * 10 && cyc - t0 <= per * 11 + 16, 1);
    rdc(OFS_FLAGS, 32'h3);
    chk(irq_q, 1'b1);
    rdc(OFS_RES_HI, {30'h0, v[9:8]});
    rdc(OFS_RES_LO, {24'h0, v[7:0]});
    wr(OFS_CTRL1, {25'h0, cks, 4'h0});
    rdc(OFS_RES_HI, {24'h0, v[9:2]});
    rdc(OFS_RES_LO, {24'h0, v[1:0], 6'h0});
    rdc(OFS_FLAGS, 32'h3);
    wr(OFS_FLAGS, 32'h2);
    chk(irq_q, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(conv_power_q, 1'b0);
    rdc(OFS_CTRL0, CTRL0_RST);
    rdc(OFS_CTRL1, CTRL1_RST);
    rdc(OFS_RES_HI, 32'h0);
    rdc(OFS_RES_LO, 32'h0);
    rdc(8'h14, 32'h0, RESP_SLVERR);
    wr(OFS_RES_HI, 32'hFF, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL1, {30'h5, i[1:0]});
      chk(ref_sel_q, i[1:0]);
    end
    wr(OFS_CTRL0, 32'h3);
    rdc(OFS_CTRL0, 32'h1);
    chk(conv_power_q, 1'b1);
    wr(OFS_CTRL0, 32'h81);
    chk(channel_q, 6'h00);
    wr(OFS_CTRL0, 32'h7D);
    chk(channel_q, 6'h1F);
    wr(OFS_FLAGS, 32'h3);
    for (int i = 0; i < 6; i++) begin
      conv(cks_t[i], 6'(i + 1), per_t[i]);
    end
    // Abort mid conversion, then a start refused during recovery
    pv = lvl(6'h06);
    wr(OFS_CTRL1, 32'h14);
    wr(OFS_CTRL0, 32'h25);
    repeat (10) @(negedge ref_clk);
    wr(OFS_CTRL0, 32'h27);
    repeat (20) @(negedge ref_clk);
    wr(OFS_CTRL0, 32'h25);
    wr(OFS_CTRL0, 32'h27);
    rdc(OFS_CTRL0, 32'h25);
    repeat (20) @(negedge ref_clk);
    chk(sample_q, 1'b1);
    chk(channel_q, 6'h09);
    rdc(OFS_RES_HI, {30'h0, pv[9:8]});
    rdc(OFS_RES_LO, {24'h0, pv[7:0]});
    rdc(OFS_FLAGS, 32'h2);
    // Reserved clock code stalls; clearing the enable aborts instead
    wr(OFS_CTRL1, 32'h04);
    wr(OFS_CTRL0, 32'h27);
    repeat (100) @(negedge ref_clk);
    rdc(OFS_CTRL0, 32'h27);
    wr(OFS_CTRL0, 32'h24);
    chk(sample_q, 1'b0);
    wr(OFS_CTRL1, 32'h14);
    wr(OFS_CTRL0, 32'h25);
    repeat (20) @(negedge ref_clk);
    rdc(OFS_RES_LO, {24'h0, pv[7:0]});
    // Reset while converting switches everything off
    wr(OFS_CTRL0, 32'h27);
    rdc(OFS_CTRL0, 32'h27);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(conv_power_q, 1'b0);
    rdc(OFS_CTRL0, 32'h0);
    rdc(OFS_FLAGS, 32'h0);
    close_out();
  end
endmodule // tb
